// ===== design/atx_pkg.sv
package atx_pkg;
	localparam int ACC_W       = 32;
	localparam int WORD_W      = 16;
	localparam int DADDR_W     = 8;
	localparam int PADDR_W     = 12;
	localparam int PORT_W      = 3;
	localparam int IMM_W       = 13;
	localparam int SHIFT_W     = 4;
	localparam int SHORT_IMM_W = 8;
	localparam int DIR_FIELD_W = 7;
	localparam int DMEM_DEPTH  = 256;
	localparam int STACK_DEPTH = 4;
	localparam int STACK_PTR_W = 2;
	// cycles a table read or port input occupies, counted from acceptance
	localparam int XFER_CYCLES = 3;
	// reset values
	localparam logic [ACC_W-1:0]  ACC_RST = 32'h0000_0000;
	localparam logic [WORD_W-1:0] AUX_RST = 16'h0000;
	localparam logic              ARP_RST = 1'b0;
	localparam logic              DP_RST  = 1'b0;

	typedef enum logic [4:0] {
		OP_NOP                    = 5'b00000,
		OP_SELECT_AUX_POINTER_IMM = 5'b00001,
		OP_LOAD_PAGE_POINTER_IMM  = 5'b00010,
		OP_LOAD_ACC_IMM           = 5'b00011,
		OP_LOAD_AUX_IMM           = 5'b00100,
		OP_MULTIPLY_IMM           = 5'b00101,
		OP_LOAD_MULT_OPERAND      = 5'b00110,
		OP_TABLE_READ             = 5'b00111,
		OP_TABLE_WRITE            = 5'b01000,
		OP_PORT_IN                = 5'b01001,
		OP_PORT_OUT               = 5'b01010,
		OP_STORE_ACC_HIGH         = 5'b01011,
		OP_STORE_ACC_LOW          = 5'b01100,
		OP_STACK_PUSH             = 5'b01101,
		OP_STACK_POP              = 5'b01110,
		OP_ZERO_LOAD_HIGH         = 5'b01111,
		OP_ZERO_LOAD_LOW_UNSIGNED = 5'b10000,
		OP_SHIFTED_ACC_LOAD       = 5'b10001,
		OP_ZERO_ACCUMULATOR       = 5'b10010,
		OP_ABSOLUTE_VALUE_OP      = 5'b10011,
		OP_AND                    = 5'b10100,
		OP_OR                     = 5'b10101,
		OP_XOR                    = 5'b10110
	} atx_op_t;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_XFER1 = 2'b01,
		ST_XFER2 = 2'b10
	} atx_state_t;

	// decoded instruction handed in by the issue stage
	typedef struct packed {
		atx_op_t                op;
		logic                   aux_sel;
		logic                   indirect;
		logic [DIR_FIELD_W-1:0] dir_addr;
		logic [SHIFT_W-1:0]     shift;
		logic [PORT_W-1:0]      port;
		logic [IMM_W-1:0]       imm;
	} atx_ins_t;

	typedef struct packed {
		logic               rd;
		logic               wr;
		logic [PADDR_W-1:0] addr;
		logic [WORD_W-1:0]  wdata;
	} atx_pm_req_t;

	typedef struct packed {
		logic              rd;
		logic              wr;
		logic [PORT_W-1:0] addr;
		logic [WORD_W-1:0] wdata;
	} atx_io_req_t;

	typedef struct packed {
		logic [ACC_W-1:0]  acc;
		logic [ACC_W-1:0]  preg;
		logic [WORD_W-1:0] ar0;
		logic [WORD_W-1:0] ar1;
		logic              aux_register_pointer;
		logic              dp;
	} atx_state_view_t;
endpackage

// ===== design/atx_exec.sv
`timescale 1ns/1ns
module atx_exec #(
	parameter bit HAS_EXT_MEM = 1'b1
) (
	input  wire logic                    i_clk,
	input  wire logic                    i_reset,
	input  wire logic                    i_ins_valid,
	input  wire atx_pkg::atx_ins_t       i_ins,
	output logic                         o_ins_ready,
	output atx_pkg::atx_pm_req_t         o_pm,
	input  wire logic [15:0]             i_pm_rdata,
	output atx_pkg::atx_io_req_t         o_io,
	input  wire logic [15:0]             i_io_rdata,
	output atx_pkg::atx_state_view_t     o_view
);
	logic [15:0]            dmem [atx_pkg::DMEM_DEPTH];
	logic [31:0]            stack [atx_pkg::STACK_DEPTH];
	logic [31:0]            acc_r;
	logic [31:0]            preg_r;
	logic [15:0]            treg_r;
	logic [15:0]            ar_r [2];
	logic                   arp_r;
	logic                   dp_r;
	logic [1:0]             sp_r;
	atx_pkg::atx_state_t    state_r;
	atx_pkg::atx_op_t       xop_r;
	logic [7:0]             xaddr_r;
	atx_pkg::atx_pm_req_t   pm_r;
	atx_pkg::atx_io_req_t   io_r;
	logic                   go;
	logic [7:0]             opaddr;
	logic [15:0]            opword;
	logic [31:0]            shifted;
	logic [31:0]            stack_top;
	logic [15:0]            mult_imm;

	// operand address: direct is page bit over seven field bits, indirect low aux byte
	function automatic logic [7:0] data_addr(input atx_pkg::atx_ins_t ins, input logic dp,
		input logic [15:0] ar);
		if (ins.indirect) begin
			data_addr = ar[7:0];
		end else begin
			data_addr = {dp, ins.dir_addr};
		end
	endfunction

	// sign-extended word moved left by the load shifter
	// shifts reach 15 only; a 16-place load is the zero-load-high op
	function automatic logic [31:0] shift_load(input logic [15:0] w, input logic [3:0] sh);
		logic [31:0] ext;
		ext = {{16{w[15]}}, w};
		shift_load = ext << sh;
	endfunction

	// an offer is taken only while no transfer is in flight; ready is combinational
	assign go = i_ins_valid && o_ins_ready;
	assign o_ins_ready = (state_r == atx_pkg::ST_IDLE);
	assign opaddr = data_addr(i_ins, dp_r, ar_r[arp_r]);
	assign opword = dmem[opaddr];
	assign shifted = shift_load(opword, i_ins.shift);
	// last pushed word, which a pop restores
	assign stack_top = stack[2'(sp_r - 2'h1)];
	// the 13-bit multiply constant widened with its sign to the operand width
	assign mult_imm = {{3{i_ins.imm[12]}}, i_ins.imm};

	// transfer sequencer: table read and port input span three cycles
	// no stall input: the far side must answer in the cycle after the strobe
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			state_r <= atx_pkg::ST_IDLE;
		end else begin
			case (state_r)
				atx_pkg::ST_IDLE: begin
					if (go && (i_ins.op == atx_pkg::OP_TABLE_READ ||
					           i_ins.op == atx_pkg::OP_PORT_IN)) begin
						state_r <= atx_pkg::ST_XFER1;
					end
				end
				atx_pkg::ST_XFER1: state_r <= atx_pkg::ST_XFER2;
				atx_pkg::ST_XFER2: state_r <= atx_pkg::ST_IDLE;
				default:           state_r <= atx_pkg::ST_IDLE;
			endcase
		end
	end

	// remember the destination of a pending transfer
	// latched at acceptance, so the offered instruction may change while the word is on its way
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			xop_r   <= atx_pkg::OP_NOP;
			xaddr_r <= 8'h00;
		end else if (go) begin
			xop_r   <= i_ins.op;
			xaddr_r <= opaddr;
		end
	end

	// program memory requests; address from low accumulator bits
	// addr and wdata hold between requests, so a slow far side may latch them late
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			pm_r <= '0;
		end else begin
			pm_r.rd <= go && i_ins.op == atx_pkg::OP_TABLE_READ;
			// a part without external memory has nowhere to write the word
			pm_r.wr <= go && i_ins.op == atx_pkg::OP_TABLE_WRITE && HAS_EXT_MEM;
			if (go && (i_ins.op == atx_pkg::OP_TABLE_READ ||
			           i_ins.op == atx_pkg::OP_TABLE_WRITE)) begin
				pm_r.addr  <= acc_r[11:0];
				pm_r.wdata <= opword;
			end
		end
	end

	// port requests
	// strobes last one cycle; the port address lines keep their value afterwards
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			io_r <= '0;
		end else begin
			io_r.rd <= go && i_ins.op == atx_pkg::OP_PORT_IN;
			io_r.wr <= go && i_ins.op == atx_pkg::OP_PORT_OUT;
			if (go && (i_ins.op == atx_pkg::OP_PORT_IN || i_ins.op == atx_pkg::OP_PORT_OUT)) begin
				io_r.addr  <= i_ins.port;
				io_r.wdata <= opword;
			end
		end
	end

	// data ram writes: stores, and read data returning in the last transfer cycle
	// a store cannot meet the returning word: offers are refused during a transfer
	always_ff @(posedge i_clk) begin
		if (state_r == atx_pkg::ST_XFER2) begin
			if (xop_r == atx_pkg::OP_TABLE_READ) begin
				dmem[xaddr_r] <= i_pm_rdata;
			end else begin
				dmem[xaddr_r] <= i_io_rdata;
			end
		end else if (go && i_ins.op == atx_pkg::OP_STORE_ACC_HIGH) begin
			dmem[opaddr] <= acc_r[31:16];
		end else if (go && i_ins.op == atx_pkg::OP_STORE_ACC_LOW) begin
			dmem[opaddr] <= acc_r[15:0];
		end
	end

	// accumulator; stack contents are not reset, only the pointer
	// transfers never touch the accumulator, so only single-cycle ops land here
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			acc_r <= atx_pkg::ACC_RST;
		end else if (go) begin
			case (i_ins.op)
				atx_pkg::OP_LOAD_ACC_IMM:           acc_r <= {24'h000000, i_ins.imm[7:0]};
				atx_pkg::OP_ZERO_LOAD_HIGH:         acc_r <= {opword, 16'h0000};
				atx_pkg::OP_ZERO_LOAD_LOW_UNSIGNED: acc_r <= {16'h0000, opword};
				atx_pkg::OP_SHIFTED_ACC_LOAD:       acc_r <= shifted;
				atx_pkg::OP_ZERO_ACCUMULATOR:       acc_r <= 32'h0000_0000;
				atx_pkg::OP_ABSOLUTE_VALUE_OP:      acc_r <= acc_r[31] ? 32'(-acc_r) : acc_r;
				atx_pkg::OP_AND:                    acc_r <= acc_r & {16'h0000, opword};
				atx_pkg::OP_OR:                     acc_r <= acc_r | {16'h0000, opword};
				atx_pkg::OP_XOR:                    acc_r <= acc_r ^ {16'h0000, opword};
				atx_pkg::OP_STACK_POP:              acc_r <= stack_top;
				default:                            acc_r <= acc_r;
			endcase
		end
	end

	// hardware stack: pointer wraps, oldest entry overwritten when full
	// software keeps pushes and pops balanced; a fifth push loses the oldest word
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			sp_r <= 2'h0;
		end else if (go && i_ins.op == atx_pkg::OP_STACK_PUSH) begin
			stack[sp_r] <= acc_r;
			sp_r        <= 2'(sp_r + 2'h1);
		end else if (go && i_ins.op == atx_pkg::OP_STACK_POP) begin
			sp_r <= 2'(sp_r - 2'h1);
		end
	end

	// pointers and auxiliary registers
	// the page pointer is one bit: two pages of 128 words fill the 256-word ram
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			arp_r <= atx_pkg::ARP_RST;
			dp_r  <= atx_pkg::DP_RST;
			ar_r  <= '{atx_pkg::AUX_RST, atx_pkg::AUX_RST};
		end else if (go) begin
			if (i_ins.op == atx_pkg::OP_SELECT_AUX_POINTER_IMM) begin
				arp_r <= i_ins.imm[0];
			end
			if (i_ins.op == atx_pkg::OP_LOAD_PAGE_POINTER_IMM) begin
				dp_r <= i_ins.imm[0];
			end
			if (i_ins.op == atx_pkg::OP_LOAD_AUX_IMM) begin
				ar_r[i_ins.aux_sel] <= {8'h00, i_ins.imm[7:0]};
			end
		end
	end

	// multiplier: operand register and product
	// the product stands from the edge after the multiply until the next one
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			treg_r <= 16'h0000;
			preg_r <= 32'h0000_0000;
		end else if (go && i_ins.op == atx_pkg::OP_LOAD_MULT_OPERAND) begin
			treg_r <= opword;
		end else if (go && i_ins.op == atx_pkg::OP_MULTIPLY_IMM) begin
			preg_r <= 32'($signed(treg_r) * $signed(mult_imm));
		end
	end

	// every request and view output comes straight from a flip-flop
	assign o_pm        = pm_r;
	assign o_io        = io_r;
	assign o_view.acc  = acc_r;
	assign o_view.preg = preg_r;
	assign o_view.ar0  = ar_r[0];
	assign o_view.ar1  = ar_r[1];
	assign o_view.aux_register_pointer  = arp_r;
	assign o_view.dp   = dp_r;
endmodule // atx_exec

// ===== testbench/atx_exec_assertions.sv
`timescale 1ns/1ns
module atx_exec_assertions #(
	parameter bit HAS_EXT_MEM = 1'b1
) (
	input wire logic                     i_clk,
	input wire logic                     i_reset,
	input wire logic                     i_ins_valid,
	input wire atx_pkg::atx_ins_t        i_ins,
	input wire logic                     o_ins_ready,
	input wire atx_pkg::atx_pm_req_t     o_pm,
	input wire logic [15:0]              i_pm_rdata,
	input wire atx_pkg::atx_io_req_t     o_io,
	input wire logic [15:0]              i_io_rdata,
	input wire atx_pkg::atx_state_view_t o_view
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_reset);
	// offer taken at this edge; a net, so every property sees its sampled value
	wire logic take = i_ins_valid && o_ins_ready;
	// true on the edge where an instruction of this kind is taken
	function automatic bit go(input logic t, input atx_pkg::atx_op_t o,
		input atx_pkg::atx_op_t c);
		return t && o == c;
	endfunction
	property p_rd_addr;
		go(take, i_ins.op, atx_pkg::OP_TABLE_READ) |=>
			o_pm.rd && o_pm.addr == $past(o_view.acc[11:0]);
	endproperty
	a_rd_addr: assert property (p_rd_addr) else $error("table read address wrong");
	property p_rd_len;
		go(take, i_ins.op, atx_pkg::OP_TABLE_READ) |=> !o_ins_ready [*2] ##1 o_ins_ready;
	endproperty
	a_rd_len: assert property (p_rd_len) else $error("table read length wrong");
	property p_tw;
		go(take, i_ins.op, atx_pkg::OP_TABLE_WRITE) |=> o_pm.wr == HAS_EXT_MEM
			&& (!HAS_EXT_MEM || o_pm.addr == $past(o_view.acc[11:0]));
	endproperty
	a_tw: assert property (p_tw) else $error("table write strobe wrong");
	property p_port;
		go(take, i_ins.op, atx_pkg::OP_PORT_IN) || go(take, i_ins.op, atx_pkg::OP_PORT_OUT)
			|=> o_io.rd != o_io.wr
			&& o_io.rd == $past(i_ins.op == atx_pkg::OP_PORT_IN) && o_io.addr == $past(i_ins.port);
	endproperty
	a_port: assert property (p_port) else $error("port strobe wrong");
	property p_kimm;
		go(take, i_ins.op, atx_pkg::OP_LOAD_ACC_IMM) |=>
			o_view.acc == {24'h000000, $past(i_ins.imm[7:0])};
	endproperty
	a_kimm: assert property (p_kimm) else $error("acc immediate wrong");
	property p_arp;
		go(take, i_ins.op, atx_pkg::OP_SELECT_AUX_POINTER_IMM) |=>
			o_view.aux_register_pointer == $past(i_ins.imm[0]);
	endproperty
	a_arp: assert property (p_arp) else $error("aux pointer wrong");
	property p_dp;
		go(take, i_ins.op, atx_pkg::OP_LOAD_PAGE_POINTER_IMM) |=>
			o_view.dp == $past(i_ins.imm[0]);
	endproperty
	a_dp: assert property (p_dp) else $error("page pointer wrong");
	property p_zac;
		go(take, i_ins.op, atx_pkg::OP_ZERO_ACCUMULATOR) |=> o_view.acc == 32'h00000000;
	endproperty
	a_zac: assert property (p_zac) else $error("zero acc wrong");
	// most negative value has no positive twin and stays put
	property p_abs;
		go(take, i_ins.op, atx_pkg::OP_ABSOLUTE_VALUE_OP) |=> o_view.acc ==
			($past(o_view.acc[31]) ? -$past(o_view.acc) : $past(o_view.acc));
	endproperty
	a_abs: assert property (p_abs) else $error("absolute value wrong");
	c_rd: cover property (go(take, i_ins.op, atx_pkg::OP_TABLE_READ));
	c_tw: cover property (go(take, i_ins.op, atx_pkg::OP_TABLE_WRITE));
	c_in: cover property (go(take, i_ins.op, atx_pkg::OP_PORT_IN));
endmodule // atx_exec_assertions

bind atx_exec atx_exec_assertions #(.HAS_EXT_MEM(HAS_EXT_MEM)) u_chk (.i_clk(i_clk),
	.i_reset(i_reset), .i_ins_valid(i_ins_valid), .i_ins(i_ins), .o_ins_ready(o_ins_ready),
	.o_pm(o_pm), .i_pm_rdata(i_pm_rdata), .o_io(o_io), .i_io_rdata(i_io_rdata), .o_view(o_view));

// ===== testbench/atx_far_model.sv
`timescale 1ns/1ns
module atx_far_model (
	input  wire logic                 i_clk,
	input  wire atx_pkg::atx_pm_req_t i_pm,
	input  wire atx_pkg::atx_io_req_t i_io,
	output logic [15:0]               o_pm_rdata,
	output logic [15:0]               o_io_rdata
);
	logic [15:0] pm_mem [4096];
	logic [15:0] io_mem [8];
	// one process owns memories and read words, so each has a single driver
	// word valid the cycle after the strobe, scrambled otherwise so stale data is never trusted
	initial begin
		o_pm_rdata = 16'h0000;
		o_io_rdata = 16'h0000;
		for (int i = 0; i < 4096; i++) pm_mem[i] = 16'(i) ^ 16'h5000;
		for (int i = 0; i < 8; i++) io_mem[i] = 16'h9c41;
		forever begin
			@(posedge i_clk);
			o_pm_rdata <= i_pm.rd ? pm_mem[i_pm.addr] : ~o_pm_rdata;
			o_io_rdata <= i_io.rd ? io_mem[i_io.addr] : ~o_io_rdata;
			if (i_pm.wr) pm_mem[i_pm.addr] <= i_pm.wdata;
			if (i_io.wr) io_mem[i_io.addr] <= i_io.wdata;
		end
	end
endmodule // atx_far_model

// ===== testbench/accumulator_table_io_transfer_bench.sv
`timescale 1ns/1ns
module accumulator_table_io_transfer_bench;
	logic                     i_clk = 1'b0;
	logic                     i_reset = 1'b1;
	logic                     i_ins_valid = 1'b0;
	atx_pkg::atx_ins_t        i_ins = '0;
	logic                     rdy;
	atx_pkg::atx_pm_req_t     pm;
	atx_pkg::atx_io_req_t     io;
	atx_pkg::atx_state_view_t v;
	logic [15:0]              pm_rd;
	logic [15:0]              io_rd;
	atx_pkg::atx_pm_req_t     pm_nx;
	logic                     nx_wr_seen = 1'b0;
	int                       errors = 0;
	int                       total_checks = 0;
	always #20 i_clk = ~i_clk;
	atx_exec u_dut (.i_clk(i_clk), .i_reset(i_reset), .i_ins_valid(i_ins_valid), .i_ins(i_ins),
		.o_ins_ready(rdy), .o_pm(pm), .i_pm_rdata(pm_rd), .o_io(io), .i_io_rdata(io_rd), .o_view(v));
	atx_far_model u_far (.i_clk(i_clk), .i_pm(pm), .i_io(io), .o_pm_rdata(pm_rd),
		.o_io_rdata(io_rd));
	// a part without external memory, fed the same instructions
	atx_exec #(.HAS_EXT_MEM(1'b0)) u_nx (.i_clk(i_clk), .i_reset(i_reset),
		.i_ins_valid(i_ins_valid), .i_ins(i_ins), .o_ins_ready(), .o_pm(pm_nx),
		.i_pm_rdata(pm_rd), .o_io(), .i_io_rdata(io_rd), .o_view());
	// remembers any program write strobe from that part
	always @(posedge i_clk) begin
		if (pm_nx.wr) nx_wr_seen <= 1'b1;
	end
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// an idle cycle after each op lets far-side writes land before the checks
	task automatic op(input atx_pkg::atx_op_t c, input logic [12:0] a, input logic ind = 1'b0,
		input logic sel = 1'b0, input logic [3:0] sh = 4'h0);
		while (!rdy) @(negedge i_clk);
		i_ins = '{op:c, aux_sel:sel, indirect:ind, dir_addr:a[6:0], shift:sh, port:a[2:0],
			imm:a};
		i_ins_valid = 1'b1;
		@(negedge i_clk);
		i_ins_valid = 1'b0;
		@(negedge i_clk);
	endtask
	task automatic t_imm();
		op(atx_pkg::OP_LOAD_ACC_IMM, 13'h1fa5);
		chk("acc", 32'h000000a5, v.acc);
		op(atx_pkg::OP_LOAD_AUX_IMM, 13'h1f3c);
		chk("ar0", 32'h0000003c, v.ar0);
		op(atx_pkg::OP_SELECT_AUX_POINTER_IMM, 13'h0001);
		chk("arp", 32'h00000001, v.aux_register_pointer);
		op(atx_pkg::OP_LOAD_PAGE_POINTER_IMM, 13'h0001);
		chk("dp", 32'h00000001, v.dp);
		$display("test imm done");
	endtask
	task automatic t_store();
		op(atx_pkg::OP_STORE_ACC_LOW, 13'h0015);
		op(atx_pkg::OP_PORT_OUT, 13'h0015);
		chk("port5", 32'h000000a5, u_far.io_mem[5]);
		op(atx_pkg::OP_ZERO_LOAD_HIGH, 13'h0015);
		chk("acc", 32'h00a50000, v.acc);
		op(atx_pkg::OP_STORE_ACC_HIGH, 13'h0016);
		op(atx_pkg::OP_PORT_OUT, 13'h0016);
		chk("port6", 32'h000000a5, u_far.io_mem[6]);
		$display("test store done");
	endtask
	task automatic t_table();
		op(atx_pkg::OP_LOAD_ACC_IMM, 13'h0033);
		op(atx_pkg::OP_TABLE_READ, 13'h0020);
		op(atx_pkg::OP_PORT_OUT, 13'h0020);
		chk("port0", 32'h00005033, u_far.io_mem[0]);
		op(atx_pkg::OP_LOAD_ACC_IMM, 13'h0077);
		op(atx_pkg::OP_TABLE_WRITE, 13'h0020);
		chk("pm77", 32'h00005033, u_far.pm_mem[12'h077]);
		chk("nx_wr", 32'h00000000, nx_wr_seen);
		$display("test table done");
	endtask
	task automatic t_acc();
		op(atx_pkg::OP_PORT_IN, 13'h000b);
		op(atx_pkg::OP_ZERO_LOAD_LOW_UNSIGNED, 13'h000b);
		chk("acc", 32'h00009c41, v.acc);
		op(atx_pkg::OP_SHIFTED_ACC_LOAD, 13'h000b);
		chk("acc", 32'hffff9c41, v.acc);
		op(atx_pkg::OP_ABSOLUTE_VALUE_OP, 13'h0000);
		chk("acc", 32'h000063bf, v.acc);
		op(atx_pkg::OP_STACK_PUSH, 13'h0000);
		op(atx_pkg::OP_ZERO_ACCUMULATOR, 13'h0000);
		chk("acc", 32'h00000000, v.acc);
		op(atx_pkg::OP_STACK_POP, 13'h0000);
		chk("acc", 32'h000063bf, v.acc);
		$display("test acc done");
	endtask
	task automatic t_logic();
		op(atx_pkg::OP_AND, 13'h000b);
		chk("acc", 32'h00000001, v.acc);
		op(atx_pkg::OP_OR, 13'h000b);
		chk("acc", 32'h00009c41, v.acc);
		op(atx_pkg::OP_XOR, 13'h000b);
		chk("acc", 32'h00000000, v.acc);
		op(atx_pkg::OP_LOAD_MULT_OPERAND, 13'h000b);
		op(atx_pkg::OP_MULTIPLY_IMM, 13'h1fff);
		chk("preg", 32'h000063bf, v.preg);
		$display("test logic done");
	endtask
	// second aux register, indirect operands, load shifter and page zero
	task automatic t_indirect();
		op(atx_pkg::OP_LOAD_AUX_IMM, 13'h008b, 1'b0, 1'b1);
		chk("ar1", 32'h0000008b, v.ar1);
		op(atx_pkg::OP_ZERO_LOAD_LOW_UNSIGNED, 13'h0000, 1'b1);
		chk("acc", 32'h00009c41, v.acc);
		op(atx_pkg::OP_SHIFTED_ACC_LOAD, 13'h0000, 1'b1, 1'b0, 4'h5);
		chk("acc", 32'hfff38820, v.acc);
		op(atx_pkg::OP_SELECT_AUX_POINTER_IMM, 13'h0000);
		op(atx_pkg::OP_STORE_ACC_LOW, 13'h0000, 1'b1);
		op(atx_pkg::OP_LOAD_PAGE_POINTER_IMM, 13'h0000);
		chk("dp", 32'h00000000, v.dp);
		op(atx_pkg::OP_ZERO_LOAD_LOW_UNSIGNED, 13'h003c);
		chk("acc", 32'h00008820, v.acc);
		$display("test indirect done");
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// a hung handshake ends the run as a mismatch
	initial begin
		repeat (4000) @(posedge i_clk);
		errors++;
		stop_test();
	end
	initial begin
		repeat (8) @(negedge i_clk);
		i_reset = 1'b0;
		t_imm();
		t_store();
		t_table();
		t_acc();
		t_logic();
		t_indirect();
		stop_test();
	end
endmodule // accumulator_table_io_transfer_bench
